// File: timer_counter_pkg.sv
// package: register map, field layout and constants for the 16-bit timer counter
// Contract
// - timer mode counts on selected source clock (divider tap or external pin); match with A interrupts and clears.
// - two-bit mode field selects timer/trigger, window, pulse width, pulse output.
// - source codes other than 11 select divider taps; 11 selects external pin.
// - timer register writes held in shadow, applied at source clock after upper byte.
// - entering stop mode forces start field to 00 and halts counter.
// - while auto-capture is enabled and timer mode is running, counter copies into B every source clock.
package timer_counter_pkg;
    // ========================================
    // register byte addresses
    localparam logic [7:0] ADDR_CONTROL  = 8'h00;
    localparam logic [7:0] ADDR_COMPA    = 8'h04;
    localparam logic [7:0] ADDR_COMPB    = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0C;
    localparam logic [7:0] ADDR_MASK     = 8'h10;
    localparam logic [7:0] ADDR_COUNT    = 8'h14;
    // ========================================
    // control fields and reset values
    localparam int          MODE_LSB     = 0;
    localparam int          CLK_LSB      = 2;
    localparam int          START_LSB    = 4;
    localparam int          CAP_BIT      = 6;
    localparam int          TFF_BIT      = 7;
    localparam logic [1:0]  START_OFF    = 2'h0;
    localparam logic [1:0]  CLK_EXT      = 2'h3;
    localparam logic [1:0]  MODE_TIMER   = 2'h0;
    localparam logic [1:0]  MODE_PULSE   = 2'h3;
    localparam logic [7:0]  CONTROL_RST  = 8'h00;
    localparam logic [15:0] TREG_RST     = 16'hFFFF;
    // divider taps: counts of clk cycles per source tick (plain defaults)
    localparam logic [11:0] TAP0_DIV     = 12'h800;
    localparam logic [11:0] TAP1_DIV     = 12'h080;
    localparam logic [11:0] TAP2_DIV     = 12'h008;
    localparam logic [11:0] TAP_SLOW_DIV = 12'h008;

    typedef struct packed {
        logic       tff;
        logic       capEn;
        logic [1:0] start;
        logic [1:0] clkSel;
        logic [1:0] mode;
    } control_t;

    typedef struct packed {
        logic [15:0] value;
        logic        pending;
    } treg_t;
endpackage : timer_counter_pkg

// File: source_tick_gen.sv
// module: source clock tick generator (divider taps or external pin edge)
`timescale 1ns/100ps
module source_tick_gen (
    input  wire logic       clk,       // system clock
    input  wire logic       rst_n,     // sync reset, low
    input  wire logic [1:0] clkSel,    // source select code
    input  wire logic       slowMode,  // low-frequency system clock active
    input  wire logic       extPin,    // external input pin, asynchronous
    output logic            tick       // one-cycle source clock pulse
);
    typedef struct packed {
        logic [11:0] div;
        logic [2:0]  sync;
        logic        tick;
    } tick_state_t;

    tick_state_t st;
    tick_state_t next_st;
    logic [11:0] limit;

    // ========================================
    // tap selection and divider
    always_comb begin
        next_st = st;
        if (slowMode) begin
            limit = timer_counter_pkg::TAP_SLOW_DIV;
        end else if (clkSel == 2'h0) begin
            limit = timer_counter_pkg::TAP0_DIV;
        end else if (clkSel == 2'h1) begin
            limit = timer_counter_pkg::TAP1_DIV;
        end else begin
            limit = timer_counter_pkg::TAP2_DIV;
        end
        next_st.sync = {st.sync[1:0], extPin};
        next_st.div  = (st.div >= limit - 12'h001) ? 12'h000 : st.div + 12'h001;
        if (clkSel == timer_counter_pkg::CLK_EXT) begin
            next_st.tick = st.sync[1] & ~st.sync[2];  // rising edge, after sync pair
        end else begin
            next_st.tick = (st.div >= limit - 12'h001);
        end
    end

    // ========================================
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : source_tick_gen

// File: timer_counter_ctrl.sv
// module: 16-bit timer counter with APB registers and match interrupt
`timescale 1ns/100ps
module timer_counter_ctrl (
    input  wire logic        clk,       // 40 MHz system clock
    input  wire logic        rst_n,     // sync reset, low
    input  wire logic        psel,      // apb select
    input  wire logic        penable,   // apb access phase
    input  wire logic        pwrite,    // apb direction
    input  wire logic [7:0]  paddr,     // apb byte address
    input  wire logic [31:0] pwdata,    // apb write data
    input  wire logic [3:0]  pstrb,     // apb byte strobes
    output logic             pready,    // apb ready
    output logic [31:0]      prdata,    // apb read data
    output logic             pslverr,   // apb error
    input  wire logic        extPin,    // external input pin
    input  wire logic        slowMode,  // low-frequency clock active
    input  wire logic        stopEntry, // pulse: entering stop mode
    output logic             irq        // level interrupt
);
    typedef struct packed {
        timer_counter_pkg::control_t ctl;
        timer_counter_pkg::treg_t    regA;
        timer_counter_pkg::treg_t    regB;
        logic [15:0]                 activeA;
        logic [15:0]                 activeB;
        logic [15:0]                 count;
        logic                        status;
        logic                        mask;
        logic [31:0]                 rdata;
        logic                        stopSeen;
    } state_t;

    state_t st;
    state_t next_st;
    logic   tick;
    logic   stopSync;
    logic   wrEn;
    logic   rdEn;
    logic   match;
    logic   running;

    source_tick_gen source_tick_gen_inst (
        .clk      (clk),
        .rst_n    (rst_n),
        .clkSel   (st.ctl.clkSel),
        .slowMode (slowMode),
        .extPin   (extPin),
        .tick     (tick)
    );

    // ========================================
    // apb access decode; single wait-free answer
    assign wrEn    = psel & penable & pwrite;
    assign rdEn    = psel & ~penable & ~pwrite;
    assign pready  = 1'b1;
    assign prdata  = st.rdata;
    assign pslverr = 1'b0;
    assign stopSync = stopEntry;
    assign running = (st.ctl.start != timer_counter_pkg::START_OFF);
    assign match   = running && (st.count == st.activeA);

    function automatic logic [31:0] readMux(input state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == timer_counter_pkg::ADDR_CONTROL) begin
            r = {24'h000000, s.ctl};
        end else if (a == timer_counter_pkg::ADDR_COMPA) begin
            r = {16'h0000, s.activeA};
        end else if (a == timer_counter_pkg::ADDR_COMPB) begin
            r = {16'h0000, s.activeB};
        end else if (a == timer_counter_pkg::ADDR_STATUS) begin
            r = {31'h00000000, s.status};
        end else if (a == timer_counter_pkg::ADDR_MASK) begin
            r = {31'h00000000, s.mask};
        end else if (a == timer_counter_pkg::ADDR_COUNT) begin
            r = {16'h0000, s.count};
        end
        return r;
    endfunction : readMux

    // lower byte writes only stage; upper byte arms the shadow
    function automatic timer_counter_pkg::treg_t byteWrite(
        input timer_counter_pkg::treg_t r, input logic [31:0] d, input logic [3:0] s);
        timer_counter_pkg::treg_t o;
        o = r;
        if (s[0]) begin
            o.value[7:0] = d[7:0];
        end
        if (s[1]) begin
            o.value[15:8] = d[15:8];
            o.pending     = 1'b1;
        end
        return o;
    endfunction : byteWrite

    // ========================================
    // next-state logic
    always_comb begin
        next_st = st;
        // shadows go live on the first source tick after the upper byte;
        // applied before the bus write so a same-cycle upper write stays armed
        if (tick && st.regA.pending) begin
            next_st.activeA      = st.regA.value;
            next_st.regA.pending = 1'b0;
        end
        if (tick && st.regB.pending) begin
            next_st.activeB      = st.regB.value;
            next_st.regB.pending = 1'b0;
        end
        if (rdEn) begin
            next_st.rdata = readMux(st, paddr);
        end
        if (wrEn) begin
            if (paddr == timer_counter_pkg::ADDR_CONTROL && pstrb[0]) begin
                next_st.ctl = timer_counter_pkg::control_t'(pwdata[7:0]);
            end else if (paddr == timer_counter_pkg::ADDR_COMPA) begin
                next_st.regA = byteWrite(next_st.regA, pwdata, pstrb);
            end else if (paddr == timer_counter_pkg::ADDR_COMPB
                         && st.ctl.mode == timer_counter_pkg::MODE_PULSE) begin
                next_st.regB = byteWrite(next_st.regB, pwdata, pstrb);  // write gate
            end else if (paddr == timer_counter_pkg::ADDR_STATUS && pstrb[0]) begin
                next_st.status = st.status & ~pwdata[0];
            end else if (paddr == timer_counter_pkg::ADDR_MASK && pstrb[0]) begin
                next_st.mask = pwdata[0];
            end
        end
        // counter
        if (!running) begin
            next_st.count = 16'h0000;
        end else if (tick && st.ctl.mode == timer_counter_pkg::MODE_TIMER) begin
            if (match) begin
                next_st.count  = 16'h0000;
            end else begin
                next_st.count = st.count + 16'h0001;
            end
            if (st.ctl.capEn) begin
                next_st.activeB = st.count;
            end
        end
        // set wins over a same-cycle clear
        if (tick && match && st.ctl.mode == timer_counter_pkg::MODE_TIMER) begin
            next_st.status = 1'b1;
        end
        // stop entry overrides any start written in the same cycle
        next_st.stopSeen = stopSync;
        if (stopSync && !st.stopSeen) begin
            next_st.ctl.start = timer_counter_pkg::START_OFF;
            next_st.count     = 16'h0000;
        end
    end

    // ========================================
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st         <= '0;
            st.ctl     <= timer_counter_pkg::CONTROL_RST;
            st.regA    <= {timer_counter_pkg::TREG_RST, 1'b0};
            st.regB    <= {timer_counter_pkg::TREG_RST, 1'b0};
            st.activeA <= timer_counter_pkg::TREG_RST;
            st.activeB <= timer_counter_pkg::TREG_RST;
        end else begin
            st <= next_st;
        end
    end

    assign irq = st.status & st.mask;

    // ========================================
    // checks: counter and interrupt
    a_match_sets_status: assert property (@(posedge clk) disable iff (!rst_n)
        tick && match && st.ctl.mode == timer_counter_pkg::MODE_TIMER |=> st.status)
        else $error("match did not set status");
    a_match_clears_count: assert property (@(posedge clk) disable iff (!rst_n)
        tick && match && !stopSync && st.ctl.mode == timer_counter_pkg::MODE_TIMER
        |=> st.count == 16'h0000)
        else $error("match did not clear counter");
    a_count_steps_up: assert property (@(posedge clk) disable iff (!rst_n)
        tick && running && !match && !stopSync && st.ctl.mode == 2'h0
        && !(wrEn && paddr == timer_counter_pkg::ADDR_CONTROL)
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("counter did not increment");
    a_idle_holds_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !running |=> st.count == 16'h0000)
        else $error("stopped counter not clear");
    a_stop_clears_start: assert property (@(posedge clk) disable iff (!rst_n)
        stopSync && !st.stopSeen |=> st.ctl.start == 2'h0)
        else $error("stop entry left timer started");
    a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
        tick && match && st.ctl.mode == timer_counter_pkg::MODE_TIMER && st.mask
        && !(wrEn && paddr == timer_counter_pkg::ADDR_MASK) |=> irq)
        else $error("unmasked match did not raise interrupt");
    a_status_clears: assert property (@(posedge clk) disable iff (!rst_n)
        wrEn && paddr == timer_counter_pkg::ADDR_STATUS && pstrb[0] && pwdata[0]
        && !(tick && match) |=> !st.status)
        else $error("status bit not cleared by write");
    // checks: source tick, shadows and capture
    a_tick_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        tick && st.ctl.clkSel != timer_counter_pkg::CLK_EXT |=> !tick)
        else $error("divider tick longer than one cycle");
    a_shadow_waits_tick: assert property (@(posedge clk) disable iff (!rst_n)
        !tick |=> st.activeA == $past(st.activeA))
        else $error("compare A changed without source tick");
    a_upper_arms_shadow: assert property (@(posedge clk) disable iff (!rst_n)
        wrEn && paddr == timer_counter_pkg::ADDR_COMPA && pstrb[1] |=> st.regA.pending)
        else $error("upper byte write did not arm the shadow");
    a_low_byte_stages: assert property (@(posedge clk) disable iff (!rst_n)
        wrEn && paddr == timer_counter_pkg::ADDR_COMPA && pstrb == 4'h1
        && !st.regA.pending |=> !st.regA.pending)
        else $error("lower byte write armed the shadow");
    a_b_write_gated: assert property (@(posedge clk) disable iff (!rst_n)
        wrEn && paddr == timer_counter_pkg::ADDR_COMPB
        && st.ctl.mode != timer_counter_pkg::MODE_PULSE |=> $stable(st.regB.value))
        else $error("register b written outside pulse mode");
    a_capture_copies: assert property (@(posedge clk) disable iff (!rst_n)
        tick && running && st.ctl.capEn && st.ctl.mode == 2'h0
        |=> st.activeB == $past(st.count))
        else $error("capture missed counter value");

    c_match_seen:   cover property (@(posedge clk) disable iff (!rst_n) tick && match);
    c_irq_raised:   cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
    c_stop_entry:   cover property (@(posedge clk) disable iff (!rst_n) stopSync && running);
    c_capture_on:   cover property (@(posedge clk) disable iff (!rst_n) tick && st.ctl.capEn);
    c_shadow_live:  cover property (@(posedge clk) disable iff (!rst_n) tick && st.regA.pending);
endmodule : timer_counter_ctrl

// File: timer_counter_ctrl_timer_mode_tb.sv
// testbench: timer mode, byte staging, capture, stop entry and interrupt of the timer counter
`timescale 1ns/100ps
module timer_counter_ctrl_timer_mode_tb;
    // ==========================================
    // signals and short address names
    localparam logic [7:0] CTL = timer_counter_pkg::ADDR_CONTROL;
    localparam logic [7:0] CPA = timer_counter_pkg::ADDR_COMPA;
    localparam logic [7:0] CPB = timer_counter_pkg::ADDR_COMPB;
    localparam logic [7:0] STA = timer_counter_pkg::ADDR_STATUS;
    localparam logic [7:0] MSK = timer_counter_pkg::ADDR_MASK;
    localparam logic [7:0] CNT = timer_counter_pkg::ADDR_COUNT;
    localparam int         LIMIT = 60000; // run needs about 22k cycles
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        extPin, slowMode, stopEntry, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    int          badCount, nTests, cycles;

    timer_counter_ctrl timer_counter_ctrl_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .extPin(extPin),
        .slowMode(slowMode), .stopEntry(stopEntry), .irq(irq));

    // ==========================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            badCount++;
            report_and_stop();
        end
    end

    // ==========================================
    // helpers
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one apb transfer; request held until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] r);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        // no local limit: only the cycle guard ends a stuck access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        check("pslverr", 32'h0, {31'h0, pslverr});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        xfer(1'b1, a, d, s, r);
    endtask : wr
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, 4'h0, r);
        check(what, exp, r);
    endtask : rd
    // control word: tff always 0, pulse mode included
    function automatic logic [31:0] ctl(input logic [1:0] st, input logic [1:0] cs,
                                        input logic cap, input logic [1:0] md);
        return {24'h0, 1'b0, cap, st, cs, md};
    endfunction : ctl
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq !== 1'b1 && n < 12000);
        check("irq rise", 32'h1, {31'h0, irq});
        t = cycles;
    endtask : wait_irq

    // ==========================================
    // scenarios
    task automatic t_reset;
        check("irq idle", 32'h0, {31'h0, irq});
        rd("control", CTL, {24'h0, timer_counter_pkg::CONTROL_RST});
        rd("compare a", CPA, {16'h0, timer_counter_pkg::TREG_RST});
        rd("unmapped", 8'h18, 32'h0);
        wr(CPB, 32'h1234, 4'h3);
        repeat (20) @(posedge clk);
        rd("b refused", CPB, {16'h0, timer_counter_pkg::TREG_RST});
        wr(CTL, ctl(2'h0, 2'h2, 1'b0, timer_counter_pkg::MODE_PULSE), 4'h1);
        wr(CPB, 32'h0003, 4'h3);
        repeat (20) @(posedge clk);
        rd("b pulse", CPB, 32'h0003);
        wr(CTL, ctl(2'h0, 2'h2, 1'b0, 2'h0), 4'h1);
        $display("done: reset and register b");
    endtask : t_reset
    // low byte alone must not go live; counter cleared while stopped
    task automatic t_staging;
        logic [31:0] r;
        wr(CPA, 32'h0004, 4'h1);
        wr(CTL, ctl(2'h1, 2'h2, 1'b0, 2'h0), 4'h1);
        repeat (80) @(posedge clk);
        rd("no match", STA, 32'h0);
        xfer(1'b0, CNT, 32'h0, 4'h0, r);
        check("counting", 32'h1, {31'h0, r[15:0] > 16'h4});
        wr(CTL, ctl(2'h0, 2'h2, 1'b0, 2'h0), 4'h1);
        repeat (4) @(posedge clk);
        rd("count held", CNT, 32'h0);
        wr(CPA, 32'h0000, 4'h2);
        wr(CTL, ctl(2'h1, 2'h2, 1'b0, 2'h0), 4'h1);
        repeat (60) @(posedge clk);
        rd("match", STA, 32'h1);
        wr(CTL, ctl(2'h0, 2'h2, 1'b0, 2'h0), 4'h1);
        $display("done: staging");
    endtask : t_staging
    task automatic t_irq;
        check("masked", 32'h0, {31'h0, irq});
        wr(MSK, 32'h1, 4'h1);
        @(posedge clk);
        check("unmasked", 32'h1, {31'h0, irq});
        wr(STA, 32'h1, 4'h1);
        @(posedge clk);
        check("cleared", 32'h0, {31'h0, irq});
        rd("status clear", STA, 32'h0);
        $display("done: interrupt");
    endtask : t_irq
    // match period is (a + 1) ticks for each divider tap and for slow mode
    task automatic t_period;
        logic [1:0] cs[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
        logic       sl[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
        int         dv[4] = '{2048, 128, 8, 8};
        int         t1, t2;
        for (int i = 0; i < 4; i++) begin
            slowMode <= sl[i];
            wr(CTL, ctl(2'h0, cs[i], 1'b0, 2'h0), 4'h1);
            wr(CTL, ctl(2'h1, cs[i], 1'b0, 2'h0), 4'h1);
            wait_irq(t1);
            wr(STA, 32'h1, 4'h1);
            repeat (3) @(posedge clk);
            wait_irq(t2);
            check("period", 5 * dv[i], t2 - t1);
            wr(CTL, ctl(2'h0, cs[i], 1'b0, 2'h0), 4'h1);
            wr(STA, 32'h1, 4'h1);
        end
        slowMode <= 1'b0;
        $display("done: period");
    endtask : t_period
    task automatic t_capture_stop;
        logic [31:0] r, r2;
        wr(CTL, ctl(2'h0, 2'h2, 1'b0, 2'h0), 4'h1);
        wr(CTL, ctl(2'h1, 2'h2, 1'b1, 2'h0), 4'h1);
        repeat (16) @(posedge clk);
        xfer(1'b0, CPB, 32'h0, 4'h0, r);
        check("capture", 32'h1, {31'h0, r[15:0] < 16'h5});
        // reads eight cycles apart straddle exactly one divider tick; a is 4
        repeat (5) @(posedge clk);
        xfer(1'b0, CPB, 32'h0, 4'h0, r2);
        check("capture step", (r[15:0] == 16'h4) ? 32'h0 : r + 32'h1, r2);
        stopEntry <= 1'b1;
        @(posedge clk);
        stopEntry <= 1'b0;
        wr(STA, 32'h1, 4'h1);
        repeat (80) @(posedge clk);
        rd("stop ctl", CTL, ctl(2'h0, 2'h2, 1'b1, 2'h0));
        rd("stop count", CNT, 32'h0);
        rd("stop status", STA, 32'h0);
        $display("done: capture and stop");
    endtask : t_capture_stop
    task automatic t_external;
        wr(CTL, ctl(2'h0, timer_counter_pkg::CLK_EXT, 1'b0, 2'h0), 4'h1);
        wr(CTL, ctl(2'h1, timer_counter_pkg::CLK_EXT, 1'b0, 2'h0), 4'h1);
        repeat (3) begin
            extPin <= 1'b1;
            repeat (6) @(posedge clk);
            extPin <= 1'b0;
            repeat (6) @(posedge clk);
        end
        rd("ext count", CNT, 32'h3);
        $display("done: external");
    endtask : t_external

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================
    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, extPin, slowMode, stopEntry} = '0;
        {paddr, pwdata, pstrb} = '0;
        {badCount, nTests, cycles} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_staging();
        t_irq();
        t_period();
        t_capture_stop();
        t_external();
        report_and_stop();
    end
endmodule : timer_counter_ctrl_timer_mode_tb
